// *** logic/sadc_pkg.sv ***
// package: register map, field positions, reset values and timing counts
package sadc_pkg;
  // ****************************************************************
  // register indices; the bus byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_RESULT_LOW   = 8'hc2;
  localparam logic [7:0] IDX_RESULT_HIGH  = 8'hc3;
  localparam logic [7:0] IDX_CONTROL_ONE  = 8'he1;
  localparam logic [7:0] IDX_CONTROL_TWO  = 8'he2;
  localparam logic [7:0] IDX_COMPARE_LOW  = 8'he3;
  localparam logic [7:0] IDX_COMPARE_HIGH = 8'he4;
  localparam logic [7:0] IDX_CONTROL_ZERO = 8'he8;
  localparam logic [7:0] IDX_ACQ_TIME     = 8'hf2;
  localparam logic [7:0] IDX_P0_DISCONN   = 8'hf6;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_DONE     = 7;
  localparam int BIT_START    = 6;
  localparam int BIT_TRIG_SEL = 1;
  localparam int BIT_POWER    = 0;
  localparam int BIT_POLARITY = 6;
  localparam int BIT_CMP_ON   = 5;
  localparam int BIT_CMP_OUT  = 4;
  localparam int DIV_LSB      = 4;
  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [7:0] RST_CONTROL_ONE = 8'h20;
  localparam logic [2:0] RST_DIVIDER     = 3'h2;
  localparam logic [3:0] CHAN_BANDGAP    = 4'hf;
  localparam logic [3:0] CHAN_LAST_PIN   = 4'h7;
  localparam logic [3:0] SAR_STEPS       = 4'ha;
  localparam logic [1:0] AXI_OKAY        = 2'h0;
  localparam logic [1:0] AXI_SLVERR      = 2'h2;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_ACQ,
    SADC_CONV
  } sadc_state_t;
endpackage : sadc_pkg

// *** logic/sadc_ctrl.sv ***
// sadc_ctrl: successive-approximation converter control with AXI4-Lite
//
// Summary of operation
// - done flag sets at completion, software clears
// - no new conversion while done flag is one
// - writing one to start bit launches conversion
// - busy bit reads one throughout conversion
// - selector picks pins zero-seven or band-gap
// - power off disconnects inputs, powers down
// - converter clock is system clock over two-power-code
// - trigger select enables falling-edge pin start
// - pin triggers during busy are silently dropped
// - polarity chooses greater-equal or less-than compare
// - compare output refreshed at completion only while comparator on
// - sampling lasts one plus field converter clocks
// - disconnect bit forces port pin read zero
// - result split high eight, low two bits
// - compare value split high eight, low two
// - completion clears busy, sets done, interrupt
// - pin start also sets busy bit
module sadc_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [31:0] s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic        external_start_pin,
  input  wire logic [9:0]  sar_bit_in,
  input  wire logic [7:0]  port0_pin_in,
  output logic [7:0]       port0_read_value,
  output logic [3:0]       input_channel_sel,
  output logic [8:0]       analog_input_connect,
  output logic             converter_power_on,
  output logic             sample_hold,
  output logic             conv_done_irq
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic              conv_done_flag_q;
  logic              conv_start_busy_q;
  logic [3:0]        chan_q;
  logic [2:0]        conv_clock_divider_q;
  logic              external_trigger_sel_q;
  logic              power_q;
  logic              compare_polarity_q;
  logic              comparator_on_q;
  logic              compare_output_q;
  logic [9:0]        compare_value_q;
  logic [9:0]        conv_result_q;
  logic [9:0]        sar_q;
  logic [7:0]        acq_time_field_q;
  logic [7:0]        port0_input_disconnect_q;
  sadc_pkg::sadc_state_t state_q;
  logic [7:0]        acq_cnt_q;
  logic [3:0]        step_q;
  logic [6:0]        div_cnt_q;
  logic              pin_s1_q;
  logic              pin_s2_q;
  logic              pin_s3_q;
  logic [7:0]        port0_s1_q;
  logic [7:0]        port0_s2_q;
  logic [9:0]        sar_s1_q;
  logic [9:0]        sar_s2_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [7:0]        aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane_q;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] byte_addr(input logic [31:0] a);
    byte_addr = a[9:2]; // one aligned word per register
  endfunction : byte_addr

  function automatic logic cmp_eval(input logic [9:0] r,
                                    input logic [9:0] c,
                                    input logic       pol);
    cmp_eval = pol ? (r < c) : (r >= c);
  endfunction : cmp_eval

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q   <= 1'b1;
      pin_s2_q   <= 1'b1;
      pin_s3_q   <= 1'b1;
      port0_s1_q <= 8'h00;
      port0_s2_q <= 8'h00;
      sar_s1_q   <= 10'h000;
      sar_s2_q   <= 10'h000;
    end else begin
      pin_s1_q   <= external_start_pin;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      port0_s1_q <= port0_pin_in;
      port0_s2_q <= port0_s1_q;
      sar_s1_q   <= sar_bit_in;
      sar_s2_q   <= sar_s1_q;
    end
  end

  // ****************************************************************
  // bus write capture
  // ****************************************************************
  logic       wr_fire;
  logic       wr_hit;
  logic       pin_fall;
  logic       sw_start;
  logic       start_go;
  logic       conv_tick;
  logic       finish;
  logic [6:0] div_last;

  assign wr_fire  = aw_held_q && w_held_q && !s_axil_bvalid;
  assign wr_hit   = wr_fire && w_lane_q;
  assign pin_fall = pin_s3_q && !pin_s2_q;
  assign sw_start = wr_hit && (aw_addr_q == sadc_pkg::IDX_CONTROL_ZERO)
                    && w_data_q[sadc_pkg::BIT_START];
  // pin edge only counts when selected and not busy
  assign start_go = (state_q == sadc_pkg::SADC_IDLE) && !conv_done_flag_q
                    && power_q
                    && (sw_start || (external_trigger_sel_q && pin_fall));
  assign div_last = 7'((8'h01 << conv_clock_divider_q) - 8'h01);
  assign conv_tick = (div_cnt_q == div_last);
  assign finish   = (state_q == sadc_pkg::SADC_CONV) && conv_tick
                    && (step_q == sadc_pkg::SAR_STEPS - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= byte_addr(s_axil_awaddr);
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axil_wdata[7:0];
        w_lane_q <= s_axil_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_awready <= 1'b0;
      s_axil_wready  <= 1'b0;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= sadc_pkg::AXI_OKAY;
    end else begin
      s_axil_awready <= !aw_held_q && !(s_axil_awvalid && s_axil_awready);
      s_axil_wready  <= !w_held_q && !(s_axil_wvalid && s_axil_wready);
      if (wr_fire) begin
        s_axil_bvalid <= 1'b1;
        case (aw_addr_q)
          sadc_pkg::IDX_CONTROL_ZERO, sadc_pkg::IDX_CONTROL_ONE,
          sadc_pkg::IDX_CONTROL_TWO, sadc_pkg::IDX_COMPARE_LOW,
          sadc_pkg::IDX_COMPARE_HIGH, sadc_pkg::IDX_ACQ_TIME,
          sadc_pkg::IDX_P0_DISCONN, sadc_pkg::IDX_RESULT_LOW,
          sadc_pkg::IDX_RESULT_HIGH: s_axil_bresp <= sadc_pkg::AXI_OKAY;
          default: s_axil_bresp <= sadc_pkg::AXI_SLVERR;
        endcase
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // software-written configuration
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_q                   <= 4'h0;
      conv_clock_divider_q     <= sadc_pkg::RST_DIVIDER;
      external_trigger_sel_q   <= 1'b0;
      power_q                  <= 1'b0;
      compare_polarity_q       <= 1'b0;
      comparator_on_q          <= 1'b0;
      compare_value_q          <= 10'h000;
      acq_time_field_q         <= 8'h00;
      port0_input_disconnect_q <= 8'h00;
    end else if (wr_hit) begin
      if (aw_addr_q == sadc_pkg::IDX_CONTROL_ZERO) begin
        chan_q <= w_data_q[3:0];
      end else if (aw_addr_q == sadc_pkg::IDX_CONTROL_ONE) begin
        conv_clock_divider_q   <= w_data_q[sadc_pkg::DIV_LSB +: 3];
        external_trigger_sel_q <= w_data_q[sadc_pkg::BIT_TRIG_SEL];
        power_q                <= w_data_q[sadc_pkg::BIT_POWER];
      end else if (aw_addr_q == sadc_pkg::IDX_CONTROL_TWO) begin
        compare_polarity_q <= w_data_q[sadc_pkg::BIT_POLARITY];
        comparator_on_q    <= w_data_q[sadc_pkg::BIT_CMP_ON];
      end else if (aw_addr_q == sadc_pkg::IDX_COMPARE_LOW) begin
        compare_value_q[1:0] <= w_data_q[1:0];
      end else if (aw_addr_q == sadc_pkg::IDX_COMPARE_HIGH) begin
        compare_value_q[9:2] <= w_data_q;
      end else if (aw_addr_q == sadc_pkg::IDX_ACQ_TIME) begin
        acq_time_field_q <= w_data_q;
      end else if (aw_addr_q == sadc_pkg::IDX_P0_DISCONN) begin
        port0_input_disconnect_q <= w_data_q;
      end
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= sadc_pkg::SADC_IDLE;
      div_cnt_q <= 7'h00;
      acq_cnt_q <= 8'h00;
      step_q    <= 4'h0;
      sar_q     <= 10'h000;
    end else begin
      div_cnt_q <= (start_go || conv_tick) ? 7'h00 : div_cnt_q + 7'h01;
      case (state_q)
        sadc_pkg::SADC_IDLE: begin
          if (start_go) begin
            state_q   <= sadc_pkg::SADC_ACQ;
            acq_cnt_q <= acq_time_field_q;
          end
        end
        sadc_pkg::SADC_ACQ: begin
          if (conv_tick) begin
            if (acq_cnt_q == 8'h00) begin
              state_q <= sadc_pkg::SADC_CONV;
              step_q  <= 4'h0;
            end else begin
              acq_cnt_q <= acq_cnt_q - 8'h01;
            end
          end
        end
        sadc_pkg::SADC_CONV: begin
          if (conv_tick) begin
            sar_q[4'h9 - step_q] <= sar_s2_q[4'h9 - step_q];
            step_q <= step_q + 4'h1;
            if (finish) begin
              state_q <= sadc_pkg::SADC_IDLE;
            end
          end
        end
        default: state_q <= sadc_pkg::SADC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // status, result and compare output
  // ****************************************************************
  logic [9:0] final_result;
  assign final_result = {sar_q[9:1], sar_s2_q[0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_start_busy_q <= 1'b0;
      conv_done_flag_q  <= 1'b0;
      conv_result_q     <= 10'h000;
      compare_output_q  <= 1'b0;
      conv_done_irq     <= 1'b0;
    end else begin
      conv_done_irq <= finish;
      if (start_go) begin
        conv_start_busy_q <= 1'b1;
      end else if (finish) begin
        conv_start_busy_q <= 1'b0;
      end
      if (finish) begin
        conv_done_flag_q <= 1'b1;
        conv_result_q    <= final_result;
        if (comparator_on_q) begin
          compare_output_q <= cmp_eval(final_result, compare_value_q,
                                       compare_polarity_q);
        end
      end else if (wr_hit && (aw_addr_q == sadc_pkg::IDX_CONTROL_ZERO)
                   && !w_data_q[sadc_pkg::BIT_DONE]) begin
        conv_done_flag_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // analog side and port 0
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_power_on   <= 1'b0;
      input_channel_sel    <= 4'h0;
      analog_input_connect <= 9'h000;
      sample_hold          <= 1'b0;
      port0_read_value     <= 8'h00;
    end else begin
      converter_power_on <= power_q;
      input_channel_sel  <= chan_q;
      sample_hold        <= (state_q == sadc_pkg::SADC_ACQ);
      if (!power_q) begin
        analog_input_connect <= 9'h000;
      end else if (chan_q == sadc_pkg::CHAN_BANDGAP) begin
        analog_input_connect <= 9'h100;
      end else if (chan_q <= sadc_pkg::CHAN_LAST_PIN) begin
        analog_input_connect <= 9'((9'h001) << chan_q[2:0]);
      end else begin
        analog_input_connect <= 9'h000;
      end
      port0_read_value <= port0_s2_q & ~port0_input_disconnect_q;
    end
  end

  // ****************************************************************
  // bus read
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h0000_0000;
      s_axil_rresp   <= sadc_pkg::AXI_OKAY;
    end else begin
      s_axil_arready <= !s_axil_rvalid && !(s_axil_arvalid && s_axil_arready);
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rresp  <= sadc_pkg::AXI_OKAY;
        if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_CONTROL_ZERO) begin
          s_axil_rdata <= {24'h0, conv_done_flag_q, conv_start_busy_q,
                           2'h0, chan_q};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_CONTROL_ONE) begin
          s_axil_rdata <= {25'h0, conv_clock_divider_q, 2'h0,
                           external_trigger_sel_q, power_q};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_CONTROL_TWO) begin
          s_axil_rdata <= {25'h0, compare_polarity_q, comparator_on_q,
                           compare_output_q, 4'h0};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_COMPARE_LOW) begin
          s_axil_rdata <= {30'h0, compare_value_q[1:0]};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_COMPARE_HIGH) begin
          s_axil_rdata <= {24'h0, compare_value_q[9:2]};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_ACQ_TIME) begin
          s_axil_rdata <= {24'h0, acq_time_field_q};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_P0_DISCONN) begin
          s_axil_rdata <= {24'h0, port0_input_disconnect_q};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_RESULT_LOW) begin
          s_axil_rdata <= {30'h0, conv_result_q[1:0]};
        end else if (byte_addr(s_axil_araddr) == sadc_pkg::IDX_RESULT_HIGH) begin
          s_axil_rdata <= {24'h0, conv_result_q[9:2]};
        end else begin
          s_axil_rdata <= 32'h0000_0000;
          s_axil_rresp <= sadc_pkg::AXI_SLVERR;
        end
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end
endmodule : sadc_ctrl

// *** tb/sadc_ctrl_asserts.sv ***
// checker: port-level properties of the converter control
module sadc_ctrl_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] port0_pin_in,
  input wire logic [7:0] port0_read_value,
  input wire logic [3:0] input_channel_sel,
  input wire logic [8:0] analog_input_connect,
  input wire logic       converter_power_on,
  input wire logic       sample_hold,
  input wire logic       conv_done_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // properties
  // ****
  power_off_a: assert property (
    !converter_power_on && $stable(converter_power_on)
    |-> analog_input_connect == 9'h000)
    else $error("input connected while powered off");
  pin_route_a: assert property (
    converter_power_on && input_channel_sel <= 4'h7
    && $stable(input_channel_sel) && $stable(converter_power_on)
    |-> analog_input_connect == (9'h001 << input_channel_sel))
    else $error("pin channel routed wrongly");
  bandgap_route_a: assert property (
    converter_power_on && input_channel_sel == 4'hf
    && $stable(input_channel_sel) && $stable(converter_power_on)
    |-> analog_input_connect == 9'h100)
    else $error("band-gap not routed");
  reserved_route_a: assert property (
    input_channel_sel inside {[4'h8:4'he]} && $stable(input_channel_sel)
    |-> analog_input_connect == 9'h000)
    else $error("reserved code connected an input");
  disc_zero_a: assert property (
    (port0_pin_in == 8'h00) [*4] |-> port0_read_value == 8'h00)
    else $error("port read high with pins low");
  irq_pulse_a: assert property (
    conv_done_irq |=> !conv_done_irq)
    else $error("completion pulse longer than one cycle");
  sar_steps_a: assert property (
    $fell(sample_hold) |-> !conv_done_irq [*8])
    else $error("completion too soon after sampling");
  irq_after_acq_a: assert property (
    conv_done_irq |-> !sample_hold && !$past(sample_hold, 2))
    else $error("completion during sampling");
  sample_power_a: assert property (
    $rose(sample_hold) |-> converter_power_on)
    else $error("sampling while powered off");
  irq_c: cover property (conv_done_irq);
  sample_c: cover property ($fell(sample_hold));
  bandgap_c: cover property (analog_input_connect == 9'h100);
endmodule : sadc_ctrl_asserts

bind sadc_ctrl sadc_ctrl_asserts sadc_ctrl_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .port0_pin_in(port0_pin_in),
  .port0_read_value(port0_read_value), .input_channel_sel(input_channel_sel),
  .analog_input_connect(analog_input_connect),
  .converter_power_on(converter_power_on), .sample_hold(sample_hold),
  .conv_done_irq(conv_done_irq));

// *** tb/tb_top.sv ***
// testbench: register access and conversion scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] SAR = 10'h2a5;
  logic        aclk, aresetn, external_start_pin, sample_hold, conv_done_irq;
  logic [31:0] s_axil_awaddr, s_axil_wdata, s_axil_araddr, s_axil_rdata;
  logic [3:0]  s_axil_wstrb, input_channel_sel;
  logic [1:0]  s_axil_bresp, s_axil_rresp, rsp;
  logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic        s_axil_rvalid, s_axil_rready, converter_power_on;
  logic [9:0]  sar_bit_in;
  logic [7:0]  port0_pin_in, port0_read_value, rdat;
  logic [8:0]  analog_input_connect;
  int          fails, compares;

  sadc_ctrl sadc_ctrl_inst (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axil_awaddr        (s_axil_awaddr),
    .s_axil_awvalid       (s_axil_awvalid),
    .s_axil_awready       (s_axil_awready),
    .s_axil_wdata         (s_axil_wdata),
    .s_axil_wstrb         (s_axil_wstrb),
    .s_axil_wvalid        (s_axil_wvalid),
    .s_axil_wready        (s_axil_wready),
    .s_axil_bresp         (s_axil_bresp),
    .s_axil_bvalid        (s_axil_bvalid),
    .s_axil_bready        (s_axil_bready),
    .s_axil_araddr        (s_axil_araddr),
    .s_axil_arvalid       (s_axil_arvalid),
    .s_axil_arready       (s_axil_arready),
    .s_axil_rdata         (s_axil_rdata),
    .s_axil_rresp         (s_axil_rresp),
    .s_axil_rvalid        (s_axil_rvalid),
    .s_axil_rready        (s_axil_rready),
    .external_start_pin   (external_start_pin),
    .sar_bit_in           (sar_bit_in),
    .port0_pin_in         (port0_pin_in),
    .port0_read_value     (port0_read_value),
    .input_channel_sel    (input_channel_sel),
    .analog_input_connect (analog_input_connect),
    .converter_power_on   (converter_power_on),
    .sample_hold          (sample_hold),
    .conv_done_irq        (conv_done_irq)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ****
  // bus and compare tasks
  // ****
  task automatic chk(string w, logic [8:0] e, logic [8:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic chk_span(string w, int e, int g);
    compares++;
    if (g < e - 1 || g > e + 1) begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, g);
    end
  endtask : chk_span

  task automatic wr(logic [7:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axil_awaddr  <= {22'h0, a, 2'h0};
    s_axil_wdata   <= {24'h0, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid  <= 1'b1;
    s_axil_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1 && n < 100);
    s_axil_bready <= 1'b0;
    rsp = s_axil_bresp;
    if (n >= 100) fails++;
  endtask : wr

  task automatic rd(logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axil_araddr  <= {22'h0, a, 2'h0};
    s_axil_arvalid <= 1'b1;
    s_axil_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1 && n < 100);
    s_axil_rready <= 1'b0;
    rdat = s_axil_rdata[7:0];
    rsp = s_axil_rresp;
    if (n >= 100) fails++;
  endtask : rd

  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, rdat});
  endtask : rdchk

  task automatic wait_irq(int lim, output int n);
    n = 0;
    while (conv_done_irq !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (n >= lim) fails++;
  endtask : wait_irq

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    logic [7:0] a [9];
    a = '{8'hc2, 8'hc3, 8'he1, 8'he2, 8'he3, 8'he4, 8'he8, 8'hf2, 8'hf6};
    foreach (a[i]) rdchk(a[i], (a[i] == 8'he1) ? 8'h20 : 8'h00);
    rd(8'hc4);
    chk("unmapped resp", {7'h0, sadc_pkg::AXI_SLVERR}, {7'h0, rsp});
    wr(sadc_pkg::IDX_RESULT_HIGH, 8'hff);
    chk("write resp", {7'h0, sadc_pkg::AXI_OKAY}, {7'h0, rsp});
    rdchk(sadc_pkg::IDX_RESULT_HIGH, 8'h00);
    wr(8'hc4, 8'hff);
    chk("unmapped wresp", {7'h0, sadc_pkg::AXI_SLVERR}, {7'h0, rsp});
  endtask : t_reset

  task automatic t_power;
    logic [3:0] c [4];
    logic [8:0] e [4];
    c = '{4'h0, 4'h7, 4'h8, 4'hf};
    e = '{9'h001, 9'h080, 9'h000, 9'h100};
    wr(sadc_pkg::IDX_CONTROL_ONE, 8'h00);
    wr(sadc_pkg::IDX_CONTROL_ZERO, 8'h43);
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h03);
    chk("connect off", 9'h000, analog_input_connect);
    chk("power off", 9'h000, {8'h0, converter_power_on});
    wr(sadc_pkg::IDX_CONTROL_ONE, 8'h01);
    foreach (c[i]) begin
      wr(sadc_pkg::IDX_CONTROL_ZERO, {4'h0, c[i]});
      repeat (3) @(posedge aclk);
      chk("connect", e[i], analog_input_connect);
      chk("channel", {5'h0, c[i]}, {5'h0, input_channel_sel});
    end
    chk("power on", 9'h001, {8'h0, converter_power_on});
  endtask : t_power

  task automatic t_conv(logic [2:0] dv, logic [7:0] aq, logic [9:0] cm,
                        logic [7:0] c2, logic o, int en);
    int n;
    wr(sadc_pkg::IDX_CONTROL_ONE, {1'b0, dv, 4'h1});
    wr(sadc_pkg::IDX_ACQ_TIME, aq);
    wr(sadc_pkg::IDX_COMPARE_HIGH, cm[9:2]);
    wr(sadc_pkg::IDX_COMPARE_LOW, {6'h0, cm[1:0]});
    rdchk(sadc_pkg::IDX_COMPARE_LOW, {6'h0, cm[1:0]});
    rdchk(sadc_pkg::IDX_COMPARE_HIGH, cm[9:2]);
    wr(sadc_pkg::IDX_CONTROL_TWO, c2);
    wr(sadc_pkg::IDX_CONTROL_ZERO, 8'h43);
    wait_irq(5000, n);
    chk_span("conversion cycles", en, n);
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h83);
    rdchk(sadc_pkg::IDX_RESULT_HIGH, SAR[9:2]);
    rdchk(sadc_pkg::IDX_RESULT_LOW, {6'h0, SAR[1:0]});
    rdchk(sadc_pkg::IDX_CONTROL_TWO, c2 | {3'h0, o, 4'h0});
    wr(sadc_pkg::IDX_CONTROL_ZERO, 8'hc3);
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h83);
    wr(sadc_pkg::IDX_CONTROL_ZERO, 8'h03);
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h03);
  endtask : t_conv

  task automatic t_ext;
    int n;
    wr(sadc_pkg::IDX_CONTROL_ONE, 8'h73);
    wr(sadc_pkg::IDX_CONTROL_ZERO, 8'h05);
    external_start_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h45);
    external_start_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    external_start_pin <= 1'b0;
    wait_irq(3000, n);
    external_start_pin <= 1'b1;
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h85);
    wr(sadc_pkg::IDX_CONTROL_ZERO, 8'h05);
    repeat (8) @(posedge aclk);
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h05);
    wr(sadc_pkg::IDX_CONTROL_ONE, 8'h71);
    external_start_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    rdchk(sadc_pkg::IDX_CONTROL_ZERO, 8'h05);
    external_start_pin <= 1'b1;
  endtask : t_ext

  task automatic t_port;
    wr(sadc_pkg::IDX_P0_DISCONN, 8'h0f);
    rdchk(sadc_pkg::IDX_P0_DISCONN, 8'h0f);
    repeat (4) @(posedge aclk);
    chk("port read", 9'h0f0, {1'b0, port0_read_value});
    port0_pin_in <= 8'h00;
    repeat (6) @(posedge aclk);
    chk("port read", 9'h000, {1'b0, port0_read_value});
    port0_pin_in <= 8'h5a;
    repeat (5) @(posedge aclk);
    chk("port read", 9'h050, {1'b0, port0_read_value});
  endtask : t_port
  // ****
  // main sequence and watchdog
  // ****
  initial begin
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} = 3'h0;
    {s_axil_arvalid, s_axil_rready} = 2'h0;
    {s_axil_awaddr, s_axil_wdata, s_axil_araddr} = '0;
    s_axil_wstrb = 4'h1;
    external_start_pin = 1'b1;
    sar_bit_in = SAR;
    port0_pin_in = 8'hff;
    fails = 0;
    compares = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_power();
    t_conv(3'h1, 8'h03, 10'h2a5, 8'h20, 1'b1, 28);
    t_conv(3'h0, 8'h05, 10'h2a5, 8'h60, 1'b0, 16);
    t_conv(3'h0, 8'h00, 10'h2a6, 8'h60, 1'b1, 11);
    t_port();
    t_ext();
    end_sim();
  end

  initial begin
    #8000000;
    fails++;
    end_sim();
  end
endmodule : tb_top
